// ---- src/irc_regs.vh ----
`ifndef IRC_REGS_VH
`define IRC_REGS_VH

// ************************************************************
// register offsets (byte addresses, one word each)
// ************************************************************
`define IRC_ADDR_RES_LIMIT 8'h00
`define IRC_ADDR_RES_DURATION 8'h04
`define IRC_ADDR_DAY_INTERVAL 8'h08
`define IRC_ADDR_TMR_DURATION 8'h0c
`define IRC_ADDR_START_HOUR 8'h10
`define IRC_ADDR_STATUS 8'h14
`define IRC_ADDR_RESISTANCE 8'h18

// ************************************************************
// field widths and status bit positions
// ************************************************************
`define IRC_LIMIT_W 6
`define IRC_DUR_W 9
`define IRC_DAYS_W 3
`define IRC_HOUR_W 5
`define IRC_MIN_W 6
`define IRC_STAT_RELAY 0
`define IRC_STAT_RES_ACTIVE 1
`define IRC_STAT_TMR_ACTIVE 2
`define IRC_STAT_OVER_LIMIT 3
`define IRC_STAT_DAY_LSB 4

// ************************************************************
// reset values
// ************************************************************
`define IRC_RST_RES_LIMIT 6'h00
`define IRC_RST_RES_DURATION 9'h00a
`define IRC_RST_DAY_INTERVAL 3'h0
`define IRC_RST_TMR_DURATION 9'h00a
`define IRC_RST_START_HOUR 5'h10

// ************************************************************
// legal ranges (limit in tenths of an ohm, durations in minutes)
// ************************************************************
`define IRC_LIMIT_OFF 6'h00
`define IRC_LIMIT_MIN 6'h01
`define IRC_LIMIT_MAX 6'h3c
`define IRC_DUR_MIN 9'h005
`define IRC_DUR_MAX 9'h12c
`define IRC_DAYS_OFF 3'h0
`define IRC_HOUR_MAX 5'h17

// ************************************************************
// timing
// ************************************************************
`define IRC_MINUTE_S 36'h00000003c
`define IRC_CLK_HZ 36'h005f5e100
`define IRC_MINUTE_CYCLES (`IRC_MINUTE_S * `IRC_CLK_HZ)

`endif

// ---- src/irc_divider.v ----
`default_nettype none

// ************************************************************
// restoring divider, one quotient bit per clock
// ************************************************************
module irc_divider #(
    parameter W = 20
)(
    input wire clk,
    input wire reset,
    input wire start,
    input wire [W-1:0] dividend,
    input wire [W-1:0] divisor,
    output reg busy,
    output reg done,
    output reg [W-1:0] quotient
);
    localparam CW = $clog2(W + 1);
    localparam [CW-1:0] CNT_INIT = W;

    reg [W-1:0] rem;
    reg [CW-1:0] cnt;
    wire [W:0] shifted = {rem, quotient[W-1]};
    wire [W:0] diff = shifted - {1'b0, divisor};
    wire fits = (shifted >= {1'b0, divisor});

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= {W{1'b0}};
            rem <= {W{1'b0}};
            cnt <= {CW{1'b0}};
        end
        else if (start && !busy)
        begin
            busy <= 1'b1;
            done <= 1'b0;
            quotient <= dividend;
            rem <= {W{1'b0}};
            cnt <= CNT_INIT;
        end
        else if (busy)
        begin
            rem <= fits ? diff[W-1:0] : shifted[W-1:0];
            quotient <= {quotient[W-2:0], fits};
            cnt <= cnt - 1'b1;
            if (cnt == 1)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ---- src/irc_duration_timer.v ----
`default_nettype none

// ************************************************************
// minute-resolution run timer
// ************************************************************
module irc_duration_timer #(
    parameter DUR_W = 9,
    parameter TICK_W = 36,
    parameter [TICK_W-1:0] MINUTE_CYCLES = 36'h165a0bc00
)(
    input wire clk,
    input wire reset,
    input wire start,
    input wire abort,
    input wire [DUR_W-1:0] minutes,
    output reg active
);
    reg [DUR_W-1:0] remaining;
    reg [TICK_W-1:0] prescale;

    // prescaler restarts on start so the first minute is a full one
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            active <= 1'b0;
            remaining <= {DUR_W{1'b0}};
            prescale <= {TICK_W{1'b0}};
        end
        else if (abort)
        begin
            active <= 1'b0;
            remaining <= {DUR_W{1'b0}};
            prescale <= {TICK_W{1'b0}};
        end
        else if (start && !active)
        begin
            active <= 1'b1;
            remaining <= minutes;
            prescale <= {TICK_W{1'b0}};
        end
        else if (active)
        begin
            if (prescale == MINUTE_CYCLES - 1'b1)
            begin
                prescale <= {TICK_W{1'b0}};
                remaining <= remaining - 1'b1;
                if (remaining == 1)
                begin
                    active <= 1'b0;
                end
            end
            else
            begin
                prescale <= prescale + 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ---- src/irc_irrigation_ctrl.v ----
`include "irc_regs.vh"
`default_nettype none

module irc_irrigation_ctrl #(
    parameter MEAS_W = 16,
    parameter [35:0] MINUTE_CYCLES = `IRC_MINUTE_CYCLES
)(
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire measValid,
    input wire [MEAS_W-1:0] outVoltage,
    input wire [MEAS_W-1:0] outCurrent,
    input wire [`IRC_HOUR_W-1:0] todHour,
    input wire [`IRC_MIN_W-1:0] todMinute,
    output reg irrigationRelay
);
    // quotient carries tenths of an ohm, so the voltage is scaled by ten
    localparam DW = MEAS_W + 4;

    // ************************************************************
    // configuration and state
    // ************************************************************
    reg [`IRC_LIMIT_W-1:0] resLimit;
    reg [`IRC_DUR_W-1:0] resDuration;
    reg [`IRC_DAYS_W-1:0] dayInterval;
    reg [`IRC_DUR_W-1:0] tmrDuration;
    reg [`IRC_HOUR_W-1:0] startHour;
    reg [`IRC_DAYS_W-1:0] dayCount;
    reg [`IRC_HOUR_W-1:0] prevHour;
    reg prevMatch;
    reg [DW-1:0] resistance;
    reg overLimit;
    reg [DW-1:0] heldDivisor;

    reg [31:0] next_prdata;
    reg next_pslverr;
    reg [`IRC_DAYS_W-1:0] next_dayCount;

    wire divBusy;
    wire divDone;
    wire [DW-1:0] quotient;
    wire resActive;
    wire tmrActive;

    wire setupPhase = psel && !penable;
    wire writeNow = psel && penable && pready && pwrite && !pslverr;
    wire resEnabled = (resLimit != `IRC_LIMIT_OFF);
    wire tmrEnabled = (dayInterval != `IRC_DAYS_OFF);

    // ************************************************************
    // resistance measurement
    // ************************************************************
    wire [DW-1:0] dividend = {outVoltage, 3'h0} + {3'h0, outVoltage, 1'b0};
    wire [DW-1:0] divisor = {4'h0, outCurrent};

    // zero current gives no usable sample, so it is skipped
    wire divStart = measValid && !divBusy && (outCurrent != {MEAS_W{1'b0}});

    // current is valid only with the strobe, so it is held for the whole divide
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            heldDivisor <= {DW{1'b0}};
        end
        else if (divStart)
        begin
            heldDivisor <= divisor;
        end
    end

    irc_divider #(
        .W(DW)
    ) resDivider (
        .clk(clk),
        .reset(reset),
        .start(divStart),
        .dividend(dividend),
        .divisor(heldDivisor),
        .busy(divBusy),
        .done(divDone),
        .quotient(quotient)
    );

    wire aboveLimit = (quotient > {{(DW - `IRC_LIMIT_W){1'b0}}, resLimit});
    wire resStart = resEnabled && divDone && aboveLimit;

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            resistance <= {DW{1'b0}};
            overLimit <= 1'b0;
        end
        else if (divDone)
        begin
            resistance <= quotient;
            overLimit <= aboveLimit;
        end
    end

    irc_duration_timer #(
        .DUR_W(`IRC_DUR_W),
        .TICK_W(36),
        .MINUTE_CYCLES(MINUTE_CYCLES)
    ) resTimer (
        .clk(clk),
        .reset(reset),
        .start(resStart),
        .abort(!resEnabled),
        .minutes(resDuration),
        .active(resActive)
    );

    // ************************************************************
    // calendar timer
    // ************************************************************
    wire midnight = (todHour == 5'h00) && (prevHour != 5'h00);
    wire hourMatch = (todHour == startHour) && (todMinute == 6'h00);

    always @*
    begin
        next_dayCount = dayCount;
        if (midnight)
        begin
            // wraps back to zero after N days
            if (dayCount + 1'b1 >= dayInterval)
            begin
                next_dayCount = 3'h0;
            end
            else
            begin
                next_dayCount = dayCount + 1'b1;
            end
        end
    end

    // start on the edge of the match so one hour gives one run
    wire tmrStart = tmrEnabled && hourMatch && !prevMatch && (next_dayCount == 3'h0);

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prevHour <= 5'h00;
            prevMatch <= 1'b0;
        end
        else
        begin
            prevHour <= todHour;
            prevMatch <= hourMatch;
        end
    end

    irc_duration_timer #(
        .DUR_W(`IRC_DUR_W),
        .TICK_W(36),
        .MINUTE_CYCLES(MINUTE_CYCLES)
    ) calTimer (
        .clk(clk),
        .reset(reset),
        .start(tmrStart),
        .abort(!tmrEnabled),
        .minutes(tmrDuration),
        .active(tmrActive)
    );

    // ************************************************************
    // relay
    // ************************************************************
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irrigationRelay <= 1'b0;
        end
        else
        begin
            // disabled schemes are gated off as well as aborted
            irrigationRelay <= (resEnabled && resActive) || (tmrEnabled && tmrActive);
        end
    end

    // ************************************************************
    // apb decode and read data
    // ************************************************************
    wire [`IRC_LIMIT_W-1:0] wrLimit = pwdata[`IRC_LIMIT_W-1:0];
    wire [`IRC_DUR_W-1:0] wrDur = pwdata[`IRC_DUR_W-1:0];
    wire [`IRC_DAYS_W-1:0] wrDays = pwdata[`IRC_DAYS_W-1:0];
    wire [`IRC_HOUR_W-1:0] wrHour = pwdata[`IRC_HOUR_W-1:0];

    wire limitOk = (pwdata[31:`IRC_LIMIT_W] == 0)
        && ((wrLimit == `IRC_LIMIT_OFF) || ((wrLimit >= `IRC_LIMIT_MIN) && (wrLimit <= `IRC_LIMIT_MAX)));
    wire durOk = (pwdata[31:`IRC_DUR_W] == 0)
        && (wrDur >= `IRC_DUR_MIN) && (wrDur <= `IRC_DUR_MAX);
    wire daysOk = (pwdata[31:`IRC_DAYS_W] == 0);
    wire hourOk = (pwdata[31:`IRC_HOUR_W] == 0) && (wrHour <= `IRC_HOUR_MAX);

    always @*
    begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `IRC_ADDR_RES_LIMIT:
            begin
                next_prdata[`IRC_LIMIT_W-1:0] = resLimit;
                next_pslverr = pwrite && !limitOk;
            end
            `IRC_ADDR_RES_DURATION:
            begin
                next_prdata[`IRC_DUR_W-1:0] = resDuration;
                next_pslverr = pwrite && !durOk;
            end
            `IRC_ADDR_DAY_INTERVAL:
            begin
                next_prdata[`IRC_DAYS_W-1:0] = dayInterval;
                next_pslverr = pwrite && !daysOk;
            end
            `IRC_ADDR_TMR_DURATION:
            begin
                next_prdata[`IRC_DUR_W-1:0] = tmrDuration;
                next_pslverr = pwrite && !durOk;
            end
            `IRC_ADDR_START_HOUR:
            begin
                // only the hour is stored; minutes are always zero
                next_prdata[`IRC_HOUR_W-1:0] = startHour;
                next_pslverr = pwrite && !hourOk;
            end
            `IRC_ADDR_STATUS:
            begin
                next_prdata[`IRC_STAT_RELAY] = irrigationRelay;
                next_prdata[`IRC_STAT_RES_ACTIVE] = resActive;
                next_prdata[`IRC_STAT_TMR_ACTIVE] = tmrActive;
                next_prdata[`IRC_STAT_OVER_LIMIT] = overLimit;
                next_prdata[`IRC_STAT_DAY_LSB+`IRC_DAYS_W-1:`IRC_STAT_DAY_LSB] = dayCount;
                next_pslverr = pwrite;
            end
            `IRC_ADDR_RESISTANCE:
            begin
                next_prdata[DW-1:0] = resistance;
                next_pslverr = pwrite;
            end
            default:
            begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    // one wait-free answer: pready rises in the first access cycle
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (setupPhase)
        begin
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // ************************************************************
    // configuration writes
    // ************************************************************
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            resLimit <= `IRC_RST_RES_LIMIT;
            resDuration <= `IRC_RST_RES_DURATION;
            dayInterval <= `IRC_RST_DAY_INTERVAL;
            tmrDuration <= `IRC_RST_TMR_DURATION;
            startHour <= `IRC_RST_START_HOUR;
            dayCount <= 3'h0;
        end
        else
        begin
            dayCount <= next_dayCount;
            if (writeNow)
            begin
                case (paddr)
                    `IRC_ADDR_RES_LIMIT:
                    begin
                        resLimit <= wrLimit;
                    end
                    `IRC_ADDR_RES_DURATION:
                    begin
                        resDuration <= wrDur;
                    end
                    `IRC_ADDR_DAY_INTERVAL:
                    begin
                        dayInterval <= wrDays;
                        // today is day zero of the new interval
                        dayCount <= 3'h0;
                    end
                    `IRC_ADDR_TMR_DURATION:
                    begin
                        tmrDuration <= wrDur;
                    end
                    `IRC_ADDR_START_HOUR:
                    begin
                        startHour <= wrHour;
                    end
                    default:
                    begin
                        resLimit <= resLimit;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ---- testbench/irc_relay_sink.sv ----
`default_nettype none
// ****************
// irrigation system behind the relay
// ****************
module irc_relay_sink (
    input wire logic clk,
    input wire logic reset,
    input wire logic relay,
    output logic [31:0] starts,
    output logic [31:0] lastLen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] runLen;
    logic prevRelay;
    // contacts only: no feedback to the controller
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            starts <= 32'h0;
            lastLen <= 32'h0;
            runLen <= 32'h0;
            prevRelay <= 1'b0;
        end
        else
        begin
            prevRelay <= relay;
            if (relay)
                runLen <= runLen + 32'h1;
            if (relay && !prevRelay)
                starts <= starts + 32'h1;
            if (!relay && prevRelay)
            begin
                lastLen <= runLen;
                runLen <= 32'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/irc_irrigation_ctrl_checker.sv ----
`include "irc_regs.vh"
`default_nettype none
// ****************
// port checker
// ****************
module irc_irrigation_ctrl_checker #(
    parameter MEAS_W = 16,
    parameter [35:0] MINUTE_CYCLES = `IRC_MINUTE_CYCLES
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic measValid,
    input wire logic [MEAS_W-1:0] outVoltage,
    input wire logic [MEAS_W-1:0] outCurrent,
    input wire logic [`IRC_HOUR_W-1:0] todHour,
    input wire logic [`IRC_MIN_W-1:0] todMinute,
    input wire logic irrigationRelay
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [40:0] onCnt;
    // run length counted here, far too long for a repetition
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            onCnt <= 41'h0;
        else if (irrigationRelay)
            onCnt <= onCnt + 41'h1;
        else
            onCnt <= 41'h0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    AST_APB_ANSWER: assert property (s_setup |=> s_answer)
        else $error("no answer after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_ERR_UNMAPPED: assert property ((psel && !penable && (paddr > `IRC_ADDR_RESISTANCE
        || paddr[1:0] != 2'h0)) |=> pslverr)
        else $error("unmapped access accepted");
    AST_ERR_RO_WRITE: assert property ((psel && !penable && pwrite && paddr == `IRC_ADDR_STATUS)
        |=> pslverr)
        else $error("status write accepted");
    AST_ERR_UPPER: assert property ((psel && !penable && pwrite && pwdata[31:9] != 23'h0) |=> pslverr)
        else $error("wide write accepted");
    AST_READ_OK: assert property ((psel && !penable && !pwrite && paddr <= `IRC_ADDR_RESISTANCE
        && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped read refused");
    AST_RELAY_CAUSE: assert property ($rose(irrigationRelay) |-> $past(measValid, 22)
        || $past(measValid, 23) || $past(measValid, 24) || $past(todMinute, 2) == 6'h0)
        else $error("relay closed without cause");
    AST_RUN_LENGTH: assert property ($fell(irrigationRelay)
        |-> onCnt >= `IRC_DUR_MIN * MINUTE_CYCLES)
        else $error("relay run too short");
endmodule
bind irc_irrigation_ctrl irc_irrigation_ctrl_checker #(.MEAS_W(MEAS_W), .MINUTE_CYCLES(MINUTE_CYCLES)) u_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .measValid(measValid),
    .outVoltage(outVoltage), .outCurrent(outCurrent), .todHour(todHour), .todMinute(todMinute),
    .irrigationRelay(irrigationRelay));
`default_nettype wire

// ---- testbench/test_irc_irrigation_ctrl.sv ----
`default_nettype none
// ****************
// bench
// ****************
module test_irc_irrigation_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, measValid = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, starts, lastLen;
    logic pready, pslverr, irrigationRelay;
    logic [15:0] outVoltage = 16'h0, outCurrent = 16'h0;
    logic [4:0] todHour = 5'hc;
    logic [5:0] todMinute = 6'h1e;
    integer err_count = 0, check_count = 0, seed = 80;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h0, 32'ha, 32'h0, 32'ha, 32'h10, 32'h0};
    logic [7:0] ea [7] = '{8'h1c, 8'h14, 8'h00, 8'h04, 8'h0c, 8'h10, 8'h00};
    logic [31:0] ed [7] = '{32'h0, 32'h1, 32'h3d, 32'h4, 32'h12d, 32'h18, 32'h10000};
    logic [7:0] ba [9] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h0c, 8'h0c, 8'h10, 8'h10, 8'h08};
    logic [31:0] bd [9] = '{32'h1, 32'h3c, 32'h5, 32'h12c, 32'h5, 32'h12c, 32'h0, 32'h17, 32'h7};
    always #5 clk = ~clk;
    // one minute is 20 cycles so runs last 100 to 120 cycles
    irc_irrigation_ctrl #(.MEAS_W(16), .MINUTE_CYCLES(36'h14)) u_dut (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .measValid(measValid), .outVoltage(outVoltage),
        .outCurrent(outCurrent), .todHour(todHour), .todMinute(todMinute), .irrigationRelay(irrigationRelay));
    irc_relay_sink u_sink (.clk(clk), .reset(reset), .relay(irrigationRelay), .starts(starts), .lastLen(lastLen));
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic timeout;
        err_count++;
        $display("wait expired at %0t", $time);
        final_report;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] res_of(input logic [15:0] v, input logic [15:0] i);
        return (32'(v) * 32'ha) / 32'(i);
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic er);
        integer n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; pready !== 1'b1; n++)
        begin
            if (n > 20)
                timeout;
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic experr);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        cmp_bit(er, experr);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        cmp_bit(er, experr);
        if (!experr)
            cmp_word(rd, exp);
    endtask
    task automatic meas(input logic [15:0] v, input logic [15:0] i);
        @(posedge clk);
        measValid <= 1'b1;
        outVoltage <= v;
        outCurrent <= i;
        @(posedge clk);
        measValid <= 1'b0;
        outVoltage <= ~v;
        outCurrent <= ~i;
    endtask
    task automatic expect_run(input logic want, input integer len);
        integer s0, n;
        s0 = starts;
        // worst start latency is about 23 cycles
        repeat (40) @(posedge clk);
        cmp_bit(starts != s0, want);
        if (want)
        begin
            for (n = 0; irrigationRelay !== 1'b0; n++)
            begin
                if (n > 400)
                    timeout;
                @(posedge clk);
            end
            @(posedge clk);
            cmp_bit(lastLen >= len && lastLen <= len + 1, 1'b1);
        end
    endtask
    task automatic at_hour(input logic [4:0] h, input logic [5:0] m, input logic want);
        @(posedge clk);
        todHour <= h;
        todMinute <= 6'h3b;
        @(posedge clk);
        todMinute <= m;
        expect_run(want, 120);
    endtask
    task automatic new_day;
        @(posedge clk);
        todHour <= 5'h17;
        todMinute <= 6'h3b;
        @(posedge clk);
        todHour <= 5'h0;
        todMinute <= 6'h0;
    endtask
    initial
    begin
        integer k, d, n, l, c;
        logic [15:0] v, i;
        logic [31:0] r;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (k = 0; k < 6; k++)
            rd_chk(ra[k], rv[k], 1'b0);
        rd_chk(8'h1c, 32'h0, 1'b1);
        for (k = 0; k < 7; k++)
            wr_chk(ea[k], ed[k], 1'b1);
        for (k = 0; k < 6; k++)
            rd_chk(ra[k], rv[k], 1'b0);
        for (k = 0; k < 9; k++)
        begin
            wr_chk(ba[k], bd[k], 1'b0);
            rd_chk(ba[k], bd[k], 1'b0);
        end
        for (k = 0; k < 8; k++)
        begin
            r = 32'(1 + $unsigned($random(seed)) % 60);
            wr_chk(8'h00, r, 1'b0);
            rd_chk(8'h00, r, 1'b0);
        end
        $display("registers done");
        wr_chk(8'h04, 32'h5, 1'b0);
        wr_chk(8'h10, 32'h5, 1'b0);
        wr_chk(8'h0c, 32'h6, 1'b0);
        wr_chk(8'h08, 32'h2, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            l = (k == 0) ? 60 : 1 + $unsigned($random(seed)) % 60;
            c = 1 + $unsigned($random(seed)) % 50;
            wr_chk(8'h00, 32'(l), 1'b0);
            meas(16'(l * c), 16'(10 * c));
            expect_run(1'b0, 0);
            v = 16'((l + 1) * c);
            i = 16'(10 * c);
            meas(v, i);
            expect_run(1'b1, 100);
            rd_chk(8'h18, res_of(v, i), 1'b0);
        end
        meas(16'h1000, 16'h0);
        expect_run(1'b0, 0);
        wr_chk(8'h00, 32'h0, 1'b0);
        meas(16'hff00, 16'h1);
        expect_run(1'b0, 0);
        $display("resistance done");
        at_hour(5'h5, 6'h1e, 1'b0);
        at_hour(5'h6, 6'h0, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            n = (k == 3) ? 7 : k + 1;
            wr_chk(8'h08, 32'(n), 1'b0);
            for (d = 0; d <= n; d++)
            begin
                if (d > 0)
                begin
                    new_day;
                    // day count in status, last sample was over the limit
                    rd_chk(8'h14, 32'((d % n) << 4) | 32'h8, 1'b0);
                end
                at_hour(5'h5, 6'h0, d % n == 0);
            end
        end
        $display("timer done");
        wr_chk(8'h08, 32'h0, 1'b0);
        at_hour(5'h5, 6'h0, 1'b0);
        meas(16'hff00, 16'h1);
        expect_run(1'b0, 0);
        $display("both off done");
        final_report;
    end
endmodule
`default_nettype wire
